// [hpg_pkg.sv]
// Package with constants and carrier types for the host pin buffer gating block
package hpg_pkg;
	// ==========================================================
	// Widths
	localparam int HPG_DATA_W = 16;
	// Index of the buffer-enable pin's host role in the function selection vector
	localparam int HPG_SEL_EBL = 0;
	localparam int HPG_SEL_RDY = 1;
	localparam int HPG_SEL_INT = 2;
	localparam int HPG_SEL_DREQ = 3;
	localparam int HPG_SEL_DATA = 4;
	localparam int HPG_SEL_CS = 5;
	localparam int HPG_SEL_RS = 6;
	localparam int HPG_SEL_WR = 7;
	localparam int HPG_SEL_RD = 8;
	localparam int HPG_SEL_W = 9;
	// Reset values
	localparam logic HPG_BOOT_RST = 1'h0;

	// ==========================================================
	// Operating modes of the pin group
	typedef enum logic [1:0] {
		HPG_MODE_RESET = 2'h0,
		HPG_MODE_BOOT = 2'h1,
		HPG_MODE_NONBOOT = 2'h2
	} hpg_mode_t;

	// Host strobes seen at the pins (active low)
	typedef struct packed {
		logic cs_n;
		logic rs;
		logic wr_n;
		logic rd_n;
	} hpg_strobe_t;

	// Sequence outputs from the host interface logic
	typedef struct packed {
		logic rdy;
		logic irq;
		logic dreq;
	} hpg_seq_t;

	// Buffer enables for each pin group
	typedef struct packed {
		logic rdy_oe;
		logic int_oe;
		logic dreq_oe;
		logic data_oe;
		logic data_ie;
		logic cs_ie;
		logic rs_ie;
		logic wr_ie;
		logic rd_ie;
	} hpg_buf_t;
endpackage : hpg_pkg

// [hpg_gate.sv]
// Buffer gating of the host interface pins
// Summary of operation
// [R1] Buffer-enable low with host pin control active turns every host pin buffer off.
// [R2] The power monitor drives buffer-enable low whenever the external host is unpowered.
// [R3] Boot run with buffer-enable high: data buffers follow select and strobes.
// [R4] Reset with boot-select low: all host pins are general inputs, enable ignored.
// [R5] Non-boot run: pins start as general inputs until function selection changes them.
// [R6] Non-boot: software may give the buffer-enable pin its gating role.
// [R7] Non-boot: software may give each host signal its pin.
// [R8] Both pins selected for host role: that pin is gated by buffer-enable.
// [R9] Host pin selected without buffer-enable selected: buffers stay off; forbidden setting.
// [R10] Reset with boot-select high: ready driven low, other host buffers off.
// [R11] Boot run with enable high: ready, interrupt, request drivers and input buffers on.
`timescale 1ns/1ns
`default_nettype none
module hpg_gate (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// Pins from outside
	input wire logic i_boot_select_pin,
	input wire logic i_buffer_enable_pin,
	input wire hpg_pkg::hpg_strobe_t i_strobe,
	// Pin function selection, one bit per host role
	input wire logic [hpg_pkg::HPG_SEL_W-1:0] i_func_sel,
	// Sequence outputs from the host interface logic
	input wire hpg_pkg::hpg_seq_t i_seq,
	// Buffer controls and driven levels
	output logic [1:0] o_mode,
	output var hpg_pkg::hpg_buf_t o_buf,
	output var hpg_pkg::hpg_seq_t o_seq_out,
	output logic o_gpio_ebl
);
	import hpg_pkg::*;

	// ==========================================================
	// Input synchronisers
	logic boot_s1_reg, boot_s2_reg, ebl_s1_reg, ebl_s2_reg;
	logic [3:0] stb_s1_reg, stb_s2_reg;
	// Boot-select synchroniser keeps running through reset, so the strap
	// level is settled at release and the reset-state ready drive can
	// follow the pin; it has no reset of its own
	always_ff @(posedge i_ref_clk) begin
		boot_s1_reg <= i_boot_select_pin;
		boot_s2_reg <= boot_s1_reg;
	end

	// Buffer-enable synchroniser; reset low so every gated buffer starts off
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ebl_s1_reg <= 1'h0;
			ebl_s2_reg <= 1'h0;
		end else begin
			ebl_s1_reg <= i_buffer_enable_pin;
			ebl_s2_reg <= ebl_s1_reg;
		end
	end

	// Strobe synchroniser; reset to an inactive strobe pattern
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stb_s1_reg <= 4'hF;
			stb_s2_reg <= 4'hF;
		end else begin
			stb_s1_reg <= i_strobe;
			stb_s2_reg <= stb_s1_reg;
		end
	end

	// ==========================================================
	// Boot strap latched at release of reset
	// Taken once from the synchronised pin at the first edge after release;
	// later changes of the pin leave the mode alone until the next reset
	logic boot_reg, boot_next, caught_reg;
	assign boot_next = caught_reg ? boot_reg : boot_s2_reg;
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			boot_reg <= HPG_BOOT_RST;
			caught_reg <= 1'h0;
		end else begin
			boot_reg <= boot_next;
			caught_reg <= 1'h1;
		end
	end

	// Mode of the pin group; async reset forces the reset mode
	// The first cycle after release still reads as reset while the strap settles
	hpg_mode_t mode;
	always_comb begin
		case ({i_rst_n, caught_reg})
			2'b11: mode = boot_reg ? HPG_MODE_BOOT : HPG_MODE_NONBOOT;
			default: mode = HPG_MODE_RESET;
		endcase
	end
	assign o_mode = mode;

	// Pin role: boot forces the host role, non-boot follows selection
	function automatic logic role(input hpg_mode_t m, input logic [HPG_SEL_W-1:0] sel, input int idx);
		role = (m == HPG_MODE_BOOT) || ((m == HPG_MODE_NONBOOT) && sel[idx]); // [R6] [R7]
	endfunction

	// Role of every pin group, one bit per selection index
	logic [HPG_SEL_W-1:0] role_vec;
	genvar gi;
	generate
		for (gi = 0; gi < HPG_SEL_W; gi = gi + 1) begin : g_role
			assign role_vec[gi] = role(mode, i_func_sel, gi); // [R6] [R7]
		end
	endgenerate

	// ==========================================================
	// Buffer gating
	logic ebl_role, gate;
	hpg_strobe_t stb;
	assign stb = stb_s2_reg;
	assign ebl_role = role_vec[HPG_SEL_EBL]; // [R6]
	assign gate = ebl_role && ebl_s2_reg; // [R1] [R8] [R9]
	// Everything off unless gated on, except the ready driver in reset with boot strap high; a forbidden selection lands here too
	always_comb begin
		o_buf = '0; // [R4] [R5] [R10]
		o_buf.rdy_oe = (mode == HPG_MODE_RESET) && !i_rst_n && boot_s2_reg; // [R10]
		if (gate) begin
			o_buf.rdy_oe = role_vec[HPG_SEL_RDY]; // [R11]
			o_buf.int_oe = role_vec[HPG_SEL_INT]; // [R11]
			o_buf.dreq_oe = role_vec[HPG_SEL_DREQ]; // [R11]
			o_buf.cs_ie = role_vec[HPG_SEL_CS]; // [R11]
			o_buf.rs_ie = role_vec[HPG_SEL_RS]; // [R11]
			o_buf.wr_ie = role_vec[HPG_SEL_WR]; // [R11]
			o_buf.rd_ie = role_vec[HPG_SEL_RD]; // [R11]
			o_buf.data_ie = role_vec[HPG_SEL_DATA];
			// Data drivers on only for a selected read cycle
			o_buf.data_oe = o_buf.data_ie && !stb.cs_n && !stb.rd_n && stb.wr_n; // [R3]
		end
	end

	// Driven levels: ready low during reset, sequence values when running
	always_comb begin
		o_seq_out = (mode == HPG_MODE_RESET) ? '0 : i_seq; // [R10]
	end
	// Buffer-enable pin as general input while it has no gating role
	assign o_gpio_ebl = ebl_role ? 1'h0 : ebl_s2_reg; // [R4] [R5]

	// ==========================================================
	// Checks
	// Running in boot mode with the enable pin high
	sequence s_boot_run_en;
		(mode == HPG_MODE_BOOT) && ebl_s2_reg;
	endsequence
	// A selected read cycle at the synchronised strobes
	sequence s_read_cycle;
		!stb.cs_n && !stb.rd_n && stb.wr_n;
	endsequence
	// Reset held with the boot strap high
	sequence s_reset_boot;
		!i_rst_n && boot_s2_reg;
	endsequence
	// Non-boot, enable pin in its gating role and high
	sequence s_nb_gated;
		(mode == HPG_MODE_NONBOOT) && i_func_sel[HPG_SEL_EBL] && ebl_s2_reg;
	endsequence
	// Enable low leaves no buffer on
	AST_LOW_OFF: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R1]
		!ebl_s2_reg |-> (o_buf == '0)) else $error("buffers on with enable low");
	// Boot run: strobe input buffers and sequence drivers on
	AST_BOOT_ON: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R11]
		s_boot_run_en |-> o_buf.rdy_oe && o_buf.int_oe && o_buf.dreq_oe && o_buf.cs_ie
		&& o_buf.rs_ie && o_buf.wr_ie && o_buf.rd_ie) else $error("boot buffers off");
	// Boot run: data drivers on for a selected read
	AST_DATA_RD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R3]
		s_boot_run_en ##0 s_read_cycle |-> o_buf.data_oe)
		else $error("data not driven on read");
	// Boot run: data input buffer on
	AST_BOOT_DIE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R3]
		s_boot_run_en |-> o_buf.data_ie) else $error("boot data input off");
	// Boot run: no data drive without a selected host
	AST_BOOT_IDLE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R3]
		s_boot_run_en ##0 stb.cs_n |-> !o_buf.data_oe) else $error("data driven unselected");
	// Never drive the data bus against a host write
	AST_DATA_WR: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R3]
		!stb.wr_n |-> !o_buf.data_oe) else $error("data driven on write");
	// Non-boot with nothing selected: all general inputs
	AST_NB_GPIO: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R5]
		(mode == HPG_MODE_NONBOOT) && (i_func_sel == '0) |-> (o_buf == '0))
		else $error("non-boot pins not inputs");
	// Enable pin without its gating role: host buffers stay off
	AST_NO_EBL: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R9]
		(mode == HPG_MODE_NONBOOT) && !i_func_sel[HPG_SEL_EBL] |-> (o_buf == '0))
		else $error("buffers on without enable role");
	// Role selected on both pins with enable high: buffers on
	AST_SEL_GATE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R8]
		(mode == HPG_MODE_NONBOOT) && i_func_sel[HPG_SEL_EBL] && i_func_sel[HPG_SEL_CS]
		&& ebl_s2_reg |-> o_buf.cs_ie) else $error("selected pin not gated on");
	AST_SEL_RDY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R8]
		s_nb_gated ##0 i_func_sel[HPG_SEL_RDY] |-> o_buf.rdy_oe)
		else $error("ready driver not gated on");
	AST_SEL_DATA: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R8]
		s_nb_gated ##0 i_func_sel[HPG_SEL_DATA] |-> o_buf.data_ie)
		else $error("data input not gated on");
	// Signal without its host role stays a general input
	AST_UNSEL_RDY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R7]
		(mode == HPG_MODE_NONBOOT) && !i_func_sel[HPG_SEL_RDY] |-> !o_buf.rdy_oe)
		else $error("unselected ready driver on");
	// Strap stands once captured
	AST_MODE_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R5]
		caught_reg && $past(caught_reg) |-> $stable(boot_reg)) else $error("strap changed");
	// Enable pin reads as general input without its role
	AST_GPIO_EBL: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R4]
		!ebl_role |-> (o_gpio_ebl == ebl_s2_reg)) else $error("enable pin not general input");
	// Enable pin in its gating role is not a general input
	AST_GPIO_ROLE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R6]
		ebl_role |-> !o_gpio_ebl) else $error("enable pin still general input");
	// Reset with boot strap high: ready driver alone on, driving low
	AST_RST_RDY: assert property (@(posedge i_ref_clk) s_reset_boot |-> o_buf.rdy_oe // [R10]
		&& (o_buf[7:0] == 8'h00) && !o_seq_out.rdy) else $error("reset ready drive wrong");
	// Reset with boot strap low: every buffer off, enable ignored
	AST_RST_GPIO: assert property (@(posedge i_ref_clk) // [R4]
		!i_rst_n && !boot_s2_reg |-> (o_buf == '0)) else $error("buffers on in non-boot reset");
	// Driven levels stay low through reset
	AST_RST_SEQ: assert property (@(posedge i_ref_clk) // [R10]
		!i_rst_n |-> (o_seq_out == '0)) else $error("levels not low in reset");
	// Once running, driven levels follow the host logic
	AST_SEQ_RUN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R11]
		(mode != HPG_MODE_RESET) |-> (o_seq_out == i_seq)) else $error("levels not passed on");
endmodule : hpg_gate
`default_nettype wire

// [hpg_host_model.sv]
// Host side model: power monitor and host strobes
`timescale 1ns/1ns
`default_nettype none
module hpg_host_model (
	// Commands from the bench
	input wire logic i_powered,
	input wire hpg_pkg::hpg_strobe_t i_cmd,
	// Pins toward the block
	output logic o_buffer_enable_pin,
	output var hpg_pkg::hpg_strobe_t o_strobe
);
	import hpg_pkg::*;
	// Enable follows host power; strobes go idle while the host is unpowered
	assign o_buffer_enable_pin = i_powered;
	assign o_strobe = i_powered ? i_cmd : 4'hB;
endmodule : hpg_host_model
`default_nettype wire

// [host_port_pin_buffer_gating_tb_top.sv]
// Self-checking bench for the host pin buffer gating block
`timescale 1ns/1ns
`default_nettype none
module host_port_pin_buffer_gating_tb_top;
	import hpg_pkg::*;
	typedef struct packed {
		logic [8:0] sel;
		logic en;
		logic [3:0] stb;
		logic [8:0] exp;
		logic [8:0] msk;
	} hpg_tb_row_t;
	logic clk, rst_n, boot, pwr, ebl;
	logic [3:0] cmd;
	logic [8:0] sel;
	logic [2:0] seq;
	logic [1:0] o_mode;
	logic gpio_ebl;
	hpg_strobe_t stb;
	hpg_buf_t o_buf;
	hpg_seq_t o_seq_out;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	// Non-boot cases: selection, power, strobes, expected enables under a mask
	hpg_tb_row_t rows [7] = '{'{9'h000, 1'h1, 4'hB, 9'h000, 9'h1FF},
		'{9'h1FF, 1'h1, 4'hB, 9'h1CF, 9'h1EF}, '{9'h1FF, 1'h1, 4'h2, 9'h1EF, 9'h1EF},
		'{9'h1FF, 1'h1, 4'h1, 9'h1DF, 9'h1FF},
		'{9'h1FF, 1'h0, 4'hB, 9'h000, 9'h1FF}, '{9'h1FE, 1'h1, 4'hB, 9'h000, 9'h1FF},
		'{9'h003, 1'h1, 4'hB, 9'h100, 9'h1FF}};
	hpg_host_model host (.i_powered(pwr), .i_cmd(cmd), .o_buffer_enable_pin(ebl),
		.o_strobe(stb));
	hpg_gate uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_boot_select_pin(boot),
		.i_buffer_enable_pin(ebl), .i_strobe(stb), .i_func_sel(sel), .i_seq(seq),
		.o_mode(o_mode), .o_buf(o_buf), .o_seq_out(o_seq_out), .o_gpio_ebl(gpio_ebl));
	// Clock generation
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	task step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : step
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task end_of_test;
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			end_of_test;
		end
	end
	// Main sequence
	initial begin
		rst_n = 1'h0; boot = 1'h1; pwr = 1'h1; cmd = 4'hB; sel = 9'h000; seq = 3'h5;
		step(6);
		chk(o_mode, HPG_MODE_RESET);
		chk({o_buf, o_seq_out}, {9'h100, 3'h0});
		boot = 1'h0;
		step(3);
		chk(o_buf, 9'h000);
		pwr = 1'h0;
		step(3);
		chk(o_buf, 9'h000);
		rst_n = 1'h1;
		step(6);
		foreach (rows[i]) begin
			sel = rows[i].sel; pwr = rows[i].en; cmd = rows[i].stb;
			step(3);
			chk(o_buf & rows[i].msk, rows[i].exp);
		end
		chk(gpio_ebl, 1'h0);
		sel = 9'h1FE;
		step(1);
		chk(gpio_ebl, 1'h1);
		rst_n = 1'h0; boot = 1'h1; sel = 9'h000; pwr = 1'h0; cmd = 4'h2;
		step(3);
		chk({o_buf, o_seq_out}, {9'h100, 3'h0});
		rst_n = 1'h1;
		pwr = 1'h1;
		step(6);
		chk(o_mode, HPG_MODE_BOOT);
		chk(o_buf & 9'h1EF, 9'h1EF);
		chk(o_seq_out, 3'h5);
		cmd = 4'h1;
		step(3);
		chk(o_buf, 9'h1DF);
		pwr = 1'h0;
		step(3);
		chk(o_buf, 9'h000);
		end_of_test;
	end
endmodule : host_port_pin_buffer_gating_tb_top
`default_nettype wire
